// ### include/report_fields_if.sv
// snapshot fields of one report, plus the byte being selected
// framer owns the fields and index, the mux answers with the byte
`timescale 1ns/1ps
interface report_fields_if;
    logic [31:0] sow;
    logic [15:0] week;
    logic [15:0] utc_ofs;
    logic [7:0] flags;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic [15:0] year;
    logic [4:0] index;
    logic [7:0] byte_out;
    modport framer (output sow, week, utc_ofs, flags, sec, min, hour, day, month, year,
        index, input byte_out);
    modport mux (input sow, week, utc_ofs, flags, sec, min, hour, day, month, year,
        index, output byte_out);
endinterface

// ### include/timing_report_pkg.sv
// constants for the primary timing report framer
// assumes a 100 MHz clock and APB register access
package timing_report_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // pause between the pulse edge and an automatic report
    localparam int REPORT_DELAY_NS = 1000;
    localparam int REPORT_DELAY_CYC = (REPORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_W = $clog2(REPORT_DELAY_CYC + 1);
    // ----------------------------------------
    // report layout
    // ----------------------------------------
    localparam logic [7:0] PACKET_ID = 8'h8f;
    localparam logic [7:0] SUBPACKET_ID = 8'hab;
    localparam logic [4:0] REPORT_LEN = 5'h12;
    localparam logic [4:0] LAST_BYTE = 5'h11;
    localparam logic [4:0] BYTE_SOW = 5'h02;
    localparam logic [4:0] BYTE_WEEK = 5'h06;
    localparam logic [4:0] BYTE_UTC = 5'h08;
    localparam logic [4:0] BYTE_FLAGS = 5'h0a;
    localparam logic [4:0] BYTE_SEC = 5'h0b;
    localparam logic [4:0] BYTE_MIN = 5'h0c;
    localparam logic [4:0] BYTE_HOUR = 5'h0d;
    localparam logic [4:0] BYTE_DAY = 5'h0e;
    localparam logic [4:0] BYTE_MONTH = 5'h0f;
    localparam logic [4:0] BYTE_YEAR = 5'h10;
    localparam logic [31:0] SECONDS_PER_DAY = 32'h0001_5180;
    localparam logic [31:0] SECONDS_PER_WEEK = 32'h0009_3a80;
    localparam logic [7:0] FLAGS_RESET = 8'h0c;
    typedef enum logic [1:0] {
        SCALE_UTC = 2'h0,
        SCALE_GLONASS = 2'h1,
        SCALE_BEIDOU = 2'h2,
        SCALE_GALILEO = 2'h3
    } scale_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_SEND = 2'b11
    } framer_state_t;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SOW = 8'h08;
    localparam logic [7:0] ADDR_WEEK = 8'h0c;
    localparam logic [7:0] ADDR_CAL0 = 8'h10;
    localparam logic [7:0] ADDR_CAL1 = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_REQ = 1;
    localparam int CTRL_SCALE_LO = 4;
    localparam int CTRL_REF_LO = 6;
    localparam int ST_DATE_UTC = 0;
    localparam int ST_PPS_UTC = 1;
    localparam int ST_TIME_SET = 2;
    localparam int ST_UTC_KNOWN = 3;
    localparam logic [31:0] CAL0_RESET = 32'h0100_0000;
    localparam logic [31:0] CAL1_RESET = 32'h0000_0001;
endpackage

// ### testbench/report_host.sv
// host model: takes report bytes from the framer's transport side
// assumes one report at a time and that the framer holds each byte until taken
`timescale 1ns/1ps
module report_host (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic slow,
    output logic tx_ready,
    output logic [7:0] frames,
    output logic [4:0] last_at,
    output logic [31:0] sow_seen,
    output logic [7:0] rx_bytes [0:17]
);
    logic [4:0] count;
    logic tick;

    // stall every other cycle when slow, to stretch the byte handshake
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick <= 1'b0;
            tx_ready <= 1'b0;
        end
        else
        begin
            tick <= ~tick;
            tx_ready <= ~slow | tick;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 5'h00;
            frames <= 8'h00;
            last_at <= 5'h00;
        end
        else if (tx_valid && tx_ready)
        begin
            count <= tx_last ? 5'h00 : count + 5'h01;
            if (tx_last)
            begin
                frames <= frames + 8'h01;
                last_at <= count;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (tx_valid && tx_ready && count < 5'h12)
            rx_bytes[count] <= tx_data;
    end

    assign sow_seen = {rx_bytes[2], rx_bytes[3], rx_bytes[4], rx_bytes[5]};
endmodule

// ### testbench/tb_top.sv
// testbench for the primary timing report framer
// assumes the framer answers apb in one access cycle and streams to report_host
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic nrst, psel, penable, pwrite, pps_in, slow, pready, pslverr, err;
    logic [7:0] paddr, tx_data, frames;
    logic [31:0] pwdata, prdata, rd, sow, sow_exp, sow_seen;
    logic tx_valid, tx_last, tx_ready;
    logic [4:0] last_at;
    logic [7:0] rx_bytes [0:17];
    logic [1:0] sc;
    logic [3:0] st;
    logic [15:0] utc;
    logic [143:0] exp_rep;
    int fail_count = 0;
    int comparisons = 0;
    int n;

    always #5 clk = ~clk;

    primary_timing_report_framer dut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pps_in(pps_in),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
    report_host host (.clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready), .frames(frames),
        .last_at(last_at), .sow_seen(sow_seen), .rx_bytes(rx_bytes));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic pulse();
        @(posedge clk);
        pps_in <= 1'b1;
        repeat (20) @(posedge clk);
        pps_in <= 1'b0;
    endtask

    task automatic wait_frame(input logic [7:0] target);
        int k;
        k = 0;
        while (frames !== target && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        if (frames !== target)
        begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic check_report(input logic [143:0] e);
        for (int i = 0; i < 18; i++)
            check(32'(rx_bytes[i]), 32'(e[143 - 8 * i -: 8]));
        check(32'(last_at), 32'h11);
        check(sow_seen, e[127:96]);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pps_in = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, timing_report_pkg::ADDR_CAL0, 32'h0);
        check(rd, timing_report_pkg::CAL0_RESET);
        apb(1'b0, timing_report_pkg::ADDR_CAL1, 32'h0);
        check(rd, timing_report_pkg::CAL1_RESET);
        apb(1'b0, 8'h1c, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // every scale and reference code, glonass forces a zero offset
        for (int s = 0; s < 4; s++)
        begin
            sc = 2'(s);
            st = 4'(s * 5);
            sow = (s == 2) ? 32'h0000_0100 : 32'h0001_5181 + 32'(s);
            sow_exp = (s == 2) ? sow + 32'h0007_e900 : sow;
            utc = (sc == timing_report_pkg::SCALE_GLONASS) ? 16'h0 : 16'hfff2;
            slow <= sc[0];
            apb(1'b1, timing_report_pkg::ADDR_STATUS, {28'h0, st});
            apb(1'b1, timing_report_pkg::ADDR_SOW, sow);
            apb(1'b1, timing_report_pkg::ADDR_WEEK, {16'hfff2, 16'h0834 + 16'(s)});
            apb(1'b1, timing_report_pkg::ADDR_CAL0, 32'h1f17_3b3b);
            apb(1'b1, timing_report_pkg::ADDR_CAL1, 32'h07e2_000c);
            apb(1'b1, timing_report_pkg::ADDR_CTRL, {24'h0, ~sc, sc, 4'h0});
            pulse();
            repeat (10) @(posedge clk);
            apb(1'b1, timing_report_pkg::ADDR_CTRL, {24'h0, ~sc, sc, 4'h2});
            apb(1'b0, timing_report_pkg::ADDR_CTRL, 32'h0);
            check(rd, {24'h0, ~sc, sc, 4'h0});
            wait_frame(8'(s + 1));
            exp_rep = {timing_report_pkg::PACKET_ID, timing_report_pkg::SUBPACKET_ID,
                sow_exp, 16'h0834 + 16'(s), utc, ~sc, sc, ~st[3], ~st[2], st[1], st[0],
                8'h3b, 8'h3b, 8'h17, 8'h1f, 8'h0c, 16'h07e2};
            check_report(exp_rep);
        end
        // automatic broadcast with a stalling host
        slow <= 1'b1;
        apb(1'b1, timing_report_pkg::ADDR_SOW, 32'h0009_3a7f);
        apb(1'b1, timing_report_pkg::ADDR_CTRL, 32'h1);
        @(posedge clk);
        pps_in <= 1'b1;
        n = 0;
        while (tx_valid !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n >= 100 && n <= 115}, 32'h1);
        pps_in <= 1'b0;
        wait_frame(8'h05);
        exp_rep = {8'h8f, 8'hab, 32'h0009_3a7f, 16'h0837, 16'hfff2, 8'h03,
            8'h3b, 8'h3b, 8'h17, 8'h1f, 8'h0c, 16'h07e2};
        check_report(exp_rep);
        // next second carries fresh time, beidou: sunday plus one day is monday zero
        apb(1'b1, timing_report_pkg::ADDR_SOW, 32'h0001_5180);
        apb(1'b1, timing_report_pkg::ADDR_CTRL, 32'h21);
        pulse();
        wait_frame(8'h06);
        check(sow_seen, 32'h0);
        // broadcast off: a pulse alone sends nothing
        apb(1'b1, timing_report_pkg::ADDR_CTRL, 32'h0);
        pulse();
        repeat (250) @(posedge clk);
        check(32'(frames), 32'h6);
        complete_run();
    end
endmodule

// ### verilog/pps_sync.sv
// three-stage synchroniser and rising edge detect for the pulse pin
// assumes the pulse is high for many clock cycles
`timescale 1ns/1ps
module pps_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pps_in,
    output logic pps_rise
);
    logic s1;
    logic s2;
    logic s3;
    logic seen;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pps_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // settled level moves only when the last two stages agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            seen <= 1'b0;
        else if (s2 == s3)
            seen <= s3;
    end

    // one pulse when both settled stages first agree on high
    assign pps_rise = s2 & s3 & ~seen;
endmodule

// ### verilog/primary_timing_report_framer.sv
// primary timing report framer: APB registers, pulse snapshot, byte stream out
// assumes firmware keeps the time registers current; transport takes bytes on tx_ready
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module primary_timing_report_framer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pps_in,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    report_fields_if f ();
    timing_report_pkg::framer_state_t state;
    logic pps_rise;
    logic ctrl_auto;
    logic [1:0] ctrl_scale;
    logic [1:0] ctrl_ref;
    logic req_pending;
    logic [3:0] status;
    logic [31:0] sow_reg;
    logic [31:0] week_reg;
    logic [31:0] cal0;
    logic [31:0] cal1;
    logic [15:0] report_count;
    logic [timing_report_pkg::DELAY_W-1:0] delay_cnt;
    logic [31:0] next_sow;
    logic [15:0] next_utc;
    logic [7:0] next_flags;
    logic [31:0] read_mux;
    logic mapped;
    logic wr;
    logic capture;
    logic loaded_all;
    logic load;
    logic done;

    pps_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .pps_in(pps_in),
        .pps_rise(pps_rise)
    );

    report_byte_mux u_mux (
        .f(f)
    );

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        read_mux = 32'h0000_0000;
        case (paddr)
            timing_report_pkg::ADDR_CTRL:
                read_mux = {24'h00_0000, ctrl_ref, ctrl_scale, 3'h0, ctrl_auto};
            timing_report_pkg::ADDR_STATUS: read_mux = {28'h000_0000, status};
            timing_report_pkg::ADDR_SOW: read_mux = sow_reg;
            timing_report_pkg::ADDR_WEEK: read_mux = week_reg;
            timing_report_pkg::ADDR_CAL0: read_mux = cal0;
            timing_report_pkg::ADDR_CAL1: read_mux = cal1;
            timing_report_pkg::ADDR_STATE:
                read_mux = {report_count, 13'h0000, req_pending, state};
            default: mapped = 1'b0;
        endcase
    end

    assign wr = psel && penable && pready && pwrite && mapped;

    // zero-wait slave: answer one cycle after setup
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            prdata <= (psel && !penable && !pwrite) ? read_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_auto <= 1'b0;
            ctrl_scale <= timing_report_pkg::SCALE_UTC;
            ctrl_ref <= timing_report_pkg::SCALE_UTC;
        end
        else if (wr && paddr == timing_report_pkg::ADDR_CTRL)
        begin
            ctrl_auto <= pwdata[timing_report_pkg::CTRL_AUTO];
            ctrl_scale <= pwdata[timing_report_pkg::CTRL_SCALE_LO +: 2];
            ctrl_ref <= pwdata[timing_report_pkg::CTRL_REF_LO +: 2];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status <= 4'h0;
            sow_reg <= 32'h0000_0000;
            week_reg <= 32'h0000_0000;
            cal0 <= timing_report_pkg::CAL0_RESET;
            cal1 <= timing_report_pkg::CAL1_RESET;
        end
        else if (wr)
        begin
            case (paddr)
                timing_report_pkg::ADDR_STATUS: status <= pwdata[3:0];
                timing_report_pkg::ADDR_SOW: sow_reg <= pwdata;
                timing_report_pkg::ADDR_WEEK: week_reg <= pwdata;
                timing_report_pkg::ADDR_CAL0: cal0 <= pwdata;
                timing_report_pkg::ADDR_CAL1: cal1 <= {pwdata[31:16], 8'h00, pwdata[7:0]};
                default: status <= status;
            endcase
        end
    end

    // host request, set beats the clear at report start
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            req_pending <= 1'b0;
        else if (wr && paddr == timing_report_pkg::ADDR_CTRL && pwdata[timing_report_pkg::CTRL_REQ])
            req_pending <= 1'b1;
        else if (state != timing_report_pkg::ST_SEND && next_is_send())
            req_pending <= 1'b0;
    end

    function automatic logic next_is_send();
        next_is_send = (state == timing_report_pkg::ST_IDLE && req_pending
            && !(pps_rise && ctrl_auto))
            || (state == timing_report_pkg::ST_HOLD
            && delay_cnt == timing_report_pkg::DELAY_W'(timing_report_pkg::REPORT_DELAY_CYC - 1));
    endfunction

    // ----------------------------------------
    // snapshot at the pulse
    // ----------------------------------------
    always_comb
    begin
        // utc, glonass, galileo keep the sunday count
        next_sow = sow_reg;
        // beidou week starts a day later
        if (ctrl_scale == timing_report_pkg::SCALE_BEIDOU)
        begin
            if (sow_reg >= timing_report_pkg::SECONDS_PER_DAY)
                next_sow = sow_reg - timing_report_pkg::SECONDS_PER_DAY;
            else
                next_sow = sow_reg + timing_report_pkg::SECONDS_PER_WEEK
                    - timing_report_pkg::SECONDS_PER_DAY;
        end
        next_utc = (ctrl_scale == timing_report_pkg::SCALE_GLONASS) ? 16'h0000 : week_reg[31:16];
        next_flags = {ctrl_ref, ctrl_scale, ~status[timing_report_pkg::ST_UTC_KNOWN],
            ~status[timing_report_pkg::ST_TIME_SET], status[timing_report_pkg::ST_PPS_UTC],
            status[timing_report_pkg::ST_DATE_UTC]};
    end

    // a pulse during transmission is skipped so a frame never mixes two seconds
    assign capture = pps_rise && state != timing_report_pkg::ST_SEND;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            f.sow <= 32'h0000_0000;
            f.week <= 16'h0000;
            f.utc_ofs <= 16'h0000;
            f.flags <= timing_report_pkg::FLAGS_RESET;
            f.sec <= timing_report_pkg::CAL0_RESET[7:0];
            f.min <= timing_report_pkg::CAL0_RESET[15:8];
            f.hour <= timing_report_pkg::CAL0_RESET[23:16];
            f.day <= timing_report_pkg::CAL0_RESET[31:24];
            f.month <= timing_report_pkg::CAL1_RESET[7:0];
            f.year <= timing_report_pkg::CAL1_RESET[31:16];
        end
        else if (capture)
        begin
            f.sow <= next_sow;
            f.week <= week_reg[15:0];
            f.utc_ofs <= next_utc;
            f.flags <= next_flags;
            f.sec <= cal0[7:0];
            f.min <= cal0[15:8];
            f.hour <= cal0[23:16];
            f.day <= cal0[31:24];
            f.month <= cal1[7:0];
            f.year <= cal1[31:16];
        end
    end

    // ----------------------------------------
    // report sequencing
    // ----------------------------------------
    assign loaded_all = f.index == timing_report_pkg::REPORT_LEN;
    assign load = state == timing_report_pkg::ST_SEND && !loaded_all && (!tx_valid || tx_ready);
    assign done = tx_valid && tx_ready && tx_last;

    // auto broadcast waits after the pulse, request goes at once
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= timing_report_pkg::ST_IDLE;
        else
        begin
            case (state)
                timing_report_pkg::ST_IDLE:
                    if (pps_rise && ctrl_auto)
                        state <= timing_report_pkg::ST_HOLD;
                    else if (req_pending)
                        state <= timing_report_pkg::ST_SEND;
                timing_report_pkg::ST_HOLD:
                    if (next_is_send())
                        state <= timing_report_pkg::ST_SEND;
                timing_report_pkg::ST_SEND:
                    if (done)
                        state <= timing_report_pkg::ST_IDLE;
                default: state <= timing_report_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            delay_cnt <= '0;
        else if (state == timing_report_pkg::ST_HOLD)
            delay_cnt <= delay_cnt + 1'b1;
        else
            delay_cnt <= '0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            f.index <= 5'h00;
        else if (state != timing_report_pkg::ST_SEND)
            f.index <= 5'h00;
        else if (load)
            f.index <= f.index + 5'h01;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end
        else if (load)
        begin
            tx_data <= f.byte_out;
            tx_valid <= 1'b1;
            tx_last <= f.index == timing_report_pkg::LAST_BYTE;
        end
        else if (tx_ready)
        begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            report_count <= 16'h0000;
        else if (done)
            report_count <= report_count + 16'h0001;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence auto_wait;
        state == timing_report_pkg::ST_HOLD [*8];
    endsequence

    sequence reach_send;
        ##[1:120] state == timing_report_pkg::ST_SEND;
    endsequence

    chk_packet_id: assert property (tx_valid && f.index == 5'h01 |-> tx_data == 8'h8f)
        else $error("first report byte is not the packet id");
    chk_subpacket_id: assert property (tx_valid && f.index == 5'h02 |-> tx_data == 8'hab)
        else $error("second report byte is not the subpacket id");
    chk_sow_msb: assert property (tx_valid && f.index == 5'h03 |-> tx_data == f.sow[31:24])
        else $error("seconds into week msb misplaced");
    chk_week_order: assert property (tx_valid && f.index == 5'h07 |-> tx_data == f.week[15:8])
        else $error("week number not msb first");
    chk_cal_seconds: assert property (tx_valid && f.index == 5'h0c |-> tx_data == f.sec)
        else $error("seconds byte misplaced");
    chk_snap_taken: assert property (capture |=> f.sow == $past(next_sow))
        else $error("snapshot not taken at pulse");
    chk_auto_delay: assert property (state == timing_report_pkg::ST_IDLE && pps_rise && ctrl_auto
        |=> auto_wait ##0 reach_send)
        else $error("automatic report not sent after its pulse");
    chk_request_go: assert property (state == timing_report_pkg::ST_IDLE && req_pending
        && !(pps_rise && ctrl_auto) |=> state == timing_report_pkg::ST_SEND ##1 tx_valid)
        else $error("request did not start a report");
    chk_beidou_week: assert property (capture && ctrl_scale == timing_report_pkg::SCALE_BEIDOU
        && sow_reg >= 32'h0001_5180 |=> f.sow == $past(sow_reg) - 32'h0001_5180)
        else $error("beidou seconds not monday based");
    chk_glonass_zero: assert property (capture && ctrl_scale == timing_report_pkg::SCALE_GLONASS
        |=> f.utc_ofs == 16'h0000)
        else $error("glonass utc offset not zero");
    chk_time_unset: assert property (capture |=> f.flags[2] == !$past(status[2])
        && f.flags[3] == !$past(status[3]))
        else $error("time or utc unknown flag wrong");
    chk_scale_flags: assert property (capture |=> f.flags[7:4] == $past({ctrl_ref, ctrl_scale}))
        else $error("scale or reference flag field wrong");
endmodule

// ### verilog/report_byte_mux.sv
// picks report byte number index out of the snapshot fields
// purely combinational; the framer registers the result
`timescale 1ns/1ps
module report_byte_mux (
    report_fields_if.mux f
);
    always_comb
    begin
        case (f.index)
            5'h00: f.byte_out = timing_report_pkg::PACKET_ID;
            5'h01: f.byte_out = timing_report_pkg::SUBPACKET_ID;
            5'h02: f.byte_out = f.sow[31:24];
            5'h03: f.byte_out = f.sow[23:16];
            5'h04: f.byte_out = f.sow[15:8];
            5'h05: f.byte_out = f.sow[7:0];
            5'h06: f.byte_out = f.week[15:8];
            5'h07: f.byte_out = f.week[7:0];
            5'h08: f.byte_out = f.utc_ofs[15:8];
            5'h09: f.byte_out = f.utc_ofs[7:0];
            5'h0a: f.byte_out = f.flags;
            5'h0b: f.byte_out = f.sec;
            5'h0c: f.byte_out = f.min;
            5'h0d: f.byte_out = f.hour;
            5'h0e: f.byte_out = f.day;
            5'h0f: f.byte_out = f.month;
            5'h10: f.byte_out = f.year[15:8];
            5'h11: f.byte_out = f.year[7:0];
            default: f.byte_out = 8'h00;
        endcase
    end
endmodule
